// >>> hw/event_irq_pkg.sv
// event_irq_pkg: register map, field positions and carriers of the charger event logic
// assumes the serial-bus front end delivers decoded byte reads and writes
package event_irq_pkg;
	localparam logic [7:0] fault_flags_addr  = 8'h22;
	localparam logic [7:0] mask_low_addr     = 8'h23;
	localparam logic [7:0] mask_high_addr    = 8'h24;
	localparam logic [7:0] flags_reset_val   = 8'h00;
	localparam logic [7:0] mask_reset_val    = 8'h00;
	// fault flag positions
	localparam int input_fault_bit   = 7;
	localparam int battery_fault_bit = 6;
	localparam int system_fault_bit  = 5;
	localparam int path_fault_bit    = 4;
	localparam int thermal_shut_bit  = 3;
	localparam int temp_zone_bit     = 0;
	localparam logic [7:0] fault_flag_used  = 8'hF9;
	// mask low positions
	localparam int conv_done_bit     = 6;
	localparam int thermal_reg_bit   = 5;
	localparam int min_sys_bit       = 4;
	localparam int in_current_bit    = 3;
	localparam int in_voltage_bit    = 2;
	localparam int charge_timer_bit  = 1;
	localparam int watchdog_bit      = 0;
	// mask high positions
	localparam int charge_status_bit = 3;
	localparam int input_status_bit  = 0;
	localparam logic [7:0] mask_high_used   = 8'h09;
	// low pulse width on the interrupt output, in clock cycles
	localparam logic [3:0] irq_pulse_cycles = 4'h8;

	// analog event levels as seen by this block
	typedef struct packed {
		logic       input_fault;
		logic       battery_fault;
		logic       system_fault;
		logic       path_fault;
		logic       thermal_shutdown;
		logic [2:0] temp_zone;
	} fault_levels_t;

	typedef struct packed {
		logic conv_done;
		logic thermal_reg;
		logic min_sys;
		logic in_current;
		logic in_voltage;
		logic charge_timer;
		logic watchdog;
		logic charge_status;
		logic input_status;
	} charger_events_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_access_t;
endpackage

// >>> hw/charger_event_irq.sv
// charger_event_irq: fault flag latching, charger event masks and interrupt pulse
// assumes fault levels come from analog comparators (other domain), events are
// one-cycle pulses from local logic, and register access comes from the bus front end
`timescale 1ns/1ns

// Summary of operation
// - input overvoltage or sleep sets bit 7
// - battery overcurrent or overvoltage sets bit 6
// - system overvoltage or short sets bit 5
// - power-path or boost fault sets bit 4
// - thermal shutdown rising edge sets bit 3
// - temperature zone change sets bit 0
// - conversion-done mask, one-shot mode only
// - thermal regulation entry mask
// - minimum system entry and exit mask
// - input current limit entry mask
// - input voltage limit entry mask
// - charge safety timer expiry mask
// - bus watchdog expiry mask
// - input status change mask
// - charge status change mask
// - register reset clears all masks
module charger_event_irq
	import event_irq_pkg::*;
(
	input  wire logic            mclk_i,
	input  wire logic            reset_n_i,
	input  wire logic            reg_reset_i,
	input  wire logic            one_shot_mode_i,
	input  wire fault_levels_t   fault_levels_i,
	input  wire charger_events_t charger_events_i,
	input  wire reg_access_t     access_i,
	output logic [7:0]           rdata_o,
	output logic                 irq_n_o
);
	// synchroniser and edge history
	fault_levels_t   sync1_q;
	fault_levels_t   sync2_q;
	fault_levels_t   prev_q;
	logic [7:0]      set_v;

	// flags, masks and register decode
	logic [7:0]      flags_q;
	logic [7:0]      flags_d;
	logic [7:0]      mask_low_q;
	logic [7:0]      mask_high_q;
	logic [7:0]      rdata_d;
	logic            flags_rd;
	logic            low_wr;
	logic            high_wr;

	// event gating and interrupt pulse
	charger_events_t evt_mask;
	wire logic [8:0] evt_gate;
	logic            fault_fire;
	logic            evt_fire;
	logic            fire;
	logic            pulse_busy;
	logic [3:0]      pulse_cnt_q;
	logic [3:0]      pulse_cnt_d;
	logic            irq_n_d;

	// two-flop synchroniser for comparator levels
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= fault_levels_i;
			sync2_q <= sync1_q;
		end
	end

	// previous synchronised levels for edge detection
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			prev_q <= '0;
		end else begin
			prev_q <= sync2_q;
		end
	end

	// rising edges of fault conditions; any change of temperature zone
	always_comb begin
		set_v = 8'h00;
		set_v[input_fault_bit]   = sync2_q.input_fault & ~prev_q.input_fault;
		set_v[battery_fault_bit] = sync2_q.battery_fault & ~prev_q.battery_fault;
		set_v[system_fault_bit]  = sync2_q.system_fault & ~prev_q.system_fault;
		set_v[path_fault_bit]    = sync2_q.path_fault & ~prev_q.path_fault;
		set_v[thermal_shut_bit]  = sync2_q.thermal_shutdown & ~prev_q.thermal_shutdown;
		set_v[temp_zone_bit]     = sync2_q.temp_zone != prev_q.temp_zone;
	end

	// register access decode
	always_comb begin
		flags_rd = access_i.rd && access_i.addr == fault_flags_addr;
		low_wr   = access_i.wr && access_i.addr == mask_low_addr;
		high_wr  = access_i.wr && access_i.addr == mask_high_addr;
	end

	// flags clear on read; a set in the read cycle wins
	always_comb begin
		flags_d = flags_q;
		if (flags_rd) begin
			flags_d = flags_reset_val;
		end
		flags_d = (flags_d | set_v) & fault_flag_used;
	end

	// flag register
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i || reg_reset_i) begin
			flags_q <= flags_reset_val;
		end else begin
			flags_q <= flags_d;
		end
	end

	// mask low register; bit 7 is plain storage
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i || reg_reset_i) begin
			mask_low_q <= mask_reset_val;
		end else if (low_wr) begin
			mask_low_q <= access_i.wdata;
		end
	end

	// mask high register; reserved bits stay zero
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i || reg_reset_i) begin
			mask_high_q <= mask_reset_val;
		end else if (high_wr) begin
			mask_high_q <= access_i.wdata & mask_high_used;
		end
	end

	// read data select; unmapped addresses read zero
	always_comb begin
		rdata_d = rdata_o;
		if (access_i.rd) begin
			unique case (access_i.addr)
				fault_flags_addr: rdata_d = flags_q;
				mask_low_addr:    rdata_d = mask_low_q;
				mask_high_addr:   rdata_d = mask_high_q;
				default:          rdata_d = 8'h00;
			endcase
		end
	end

	// read data register
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rdata_d;
		end
	end

	// mask bit of each charger event, in the event layout
	always_comb begin
		evt_mask               = '0;
		evt_mask.conv_done     = mask_low_q[conv_done_bit] | ~one_shot_mode_i;
		evt_mask.thermal_reg   = mask_low_q[thermal_reg_bit];
		evt_mask.min_sys       = mask_low_q[min_sys_bit];
		evt_mask.in_current    = mask_low_q[in_current_bit];
		evt_mask.in_voltage    = mask_low_q[in_voltage_bit];
		evt_mask.charge_timer  = mask_low_q[charge_timer_bit];
		evt_mask.watchdog      = mask_low_q[watchdog_bit];
		evt_mask.charge_status = mask_high_q[charge_status_bit];
		evt_mask.input_status  = mask_high_q[input_status_bit];
	end

	// an event passes only while its mask bit is clear
	for (genvar b = 0; b < 9; b++) begin : gen_gate
		assign evt_gate[b] = charger_events_i[b] & ~evt_mask[b];
	end

	// fault edges always fire; charger events fire when unmasked
	always_comb begin
		fault_fire = |set_v;
		evt_fire   = |evt_gate;
		fire       = fault_fire | evt_fire;
	end

	// a pulse is running while the counter is non-zero
	always_comb begin
		pulse_busy = pulse_cnt_q != 4'h0;
	end

	// single low pulse; events during a pulse merge into it
	always_comb begin
		pulse_cnt_d = pulse_cnt_q;
		irq_n_d     = 1'b1;
		if (fire && !pulse_busy) begin
			pulse_cnt_d = irq_pulse_cycles - 4'h1;
			irq_n_d     = 1'b0;
		end else if (pulse_busy) begin
			pulse_cnt_d = pulse_cnt_q - 4'h1;
			irq_n_d     = 1'b0;
		end
	end

	// pulse counter
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			pulse_cnt_q <= 4'h0;
		end else begin
			pulse_cnt_q <= pulse_cnt_d;
		end
	end

	// interrupt output register
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			irq_n_o <= 1'b1;
		end else begin
			irq_n_o <= irq_n_d;
		end
	end
endmodule // charger_event_irq

// >>> testbench/event_irq_properties.sv
// event_irq_properties: port checks of the charger event block
// assumes a bind onto charger_event_irq, one clock domain
`timescale 1ns/1ns
module event_irq_properties
	import event_irq_pkg::*;
(
	input wire logic            mclk_i,
	input wire logic            reset_n_i,
	input wire logic            reg_reset_i,
	input wire logic            one_shot_mode_i,
	input wire fault_levels_t   fault_levels_i,
	input wire charger_events_t charger_events_i,
	input wire reg_access_t     access_i,
	input wire logic [7:0]      rdata_o,
	input wire logic            irq_n_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence clr_evt;
		reg_reset_i ##1 !access_i.wr ##1 (|charger_events_i[7:0]);
	endsequence
	sequence rd_at(logic [7:0] a);
		access_i.rd && access_i.addr == a;
	endsequence
	pulse_width_a: assert property ($fell(irq_n_o) |-> !irq_n_o [*8])
		else $error("irq pulse too short");
	fault_irq_a: assert property (|(fault_levels_i[7:3] & ~$past(fault_levels_i[7:3]))
		|-> ##[3:4] !irq_n_o) else $error("fault without irq");
	zone_irq_a: assert property ($changed(fault_levels_i.temp_zone) |-> ##[3:4] !irq_n_o)
		else $error("zone change without irq");
	unmasked_evt_a: assert property (clr_evt |=> !irq_n_o)
		else $error("cleared mask gave no irq");
	unmapped_rd_a: assert property (access_i.rd && !(access_i.addr inside
		{[fault_flags_addr:mask_high_addr]}) |=> rdata_o == 8'h00) else $error("unmapped read");
	hi_rsvd_a: assert property (rd_at(mask_high_addr) |=> (rdata_o & ~mask_high_used) == 8'h00)
		else $error("mask high reserved bits set");
	flag_rsvd_a: assert property (rd_at(fault_flags_addr) |=> rdata_o[2:1] == 2'b00)
		else $error("flag reserved bits set");
	reset_idle_a: assert property (disable iff (1'b0) !reset_n_i |=> irq_n_o && rdata_o == 8'h00)
		else $error("outputs not idle in reset");
endmodule // event_irq_properties

// >>> testbench/host_model.sv
// host_model: host side issuing decoded byte accesses
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ns
module host_model
	import event_irq_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic [7:0] rdata_i,
	output reg_access_t     access_o
);
	initial access_o = '0;
	task automatic wr(input logic [7:0] a, d);
		@(posedge mclk_i) #1 access_o = {2'b01, a, d};
		@(posedge mclk_i) #1 access_o = '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i) #1 access_o = {2'b10, a, 8'h00};
		@(posedge mclk_i) #1 access_o = '0;
		d = rdata_i;
	endtask
endmodule // host_model

// >>> testbench/charger_event_irq_tb.sv
// charger_event_irq_tb: register and event sequences with expected values
// assumes host_model and event_irq_properties are compiled first
`timescale 1ns/1ns
module charger_event_irq_tb;
	import event_irq_pkg::*;
	logic            mclk_i = 1'b0;
	logic            reset_n_i = 1'b0;
	logic            reg_reset_i = 1'b0;
	logic            one_shot_mode_i = 1'b1;
	fault_levels_t   fault_levels_i = '0;
	charger_events_t charger_events_i = '0;
	reg_access_t     access_i;
	logic [7:0]      rdata_o, d;
	logic            irq_n_o;
	int              miscompares = 0, checks_done = 0;
	always #2 mclk_i = ~mclk_i;
	charger_event_irq charger_event_irq_inst (.*);
	host_model host_model_inst (.mclk_i(mclk_i), .rdata_i(rdata_o), .access_o(access_i));
	task automatic chk(string n, logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(logic [7:0] a, e);
		host_model_inst.rd(a, d);
		chk("rdata_o", e, d);
	endtask
	task automatic evt(logic [8:0] e, logic x);
		@(posedge mclk_i) #1 charger_events_i = e;
		@(posedge mclk_i) #1 charger_events_i = '0;
		chk("irq_n_o", {7'h00, !x}, {7'h00, irq_n_o});
		repeat (10) @(posedge mclk_i);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge mclk_i);
		#1 reset_n_i = 1'b1;
		rchk(fault_flags_addr, flags_reset_val);
		rchk(mask_low_addr, mask_reset_val);
		host_model_inst.wr(mask_high_addr, 8'hFF);
		rchk(mask_high_addr, mask_high_used);
		host_model_inst.wr(fault_flags_addr, 8'hFF);
		rchk(fault_flags_addr, 8'h00);
		rchk(8'h25, 8'h00);
		$display("registers done");
		for (int k = 0; k < 7; k++) begin
			host_model_inst.wr(mask_low_addr, 8'h01 << k);
			evt(9'h004 << k, 1'b0);
			host_model_inst.wr(mask_low_addr, ~(8'h01 << k));
			evt(9'h004 << k, 1'b1);
		end
		#1 one_shot_mode_i = 1'b0;
		evt(9'h100, 1'b0);
		host_model_inst.wr(mask_high_addr, 8'h08);
		evt(9'h002, 1'b0);
		evt(9'h001, 1'b1);
		host_model_inst.wr(mask_low_addr, 8'h7F);
		@(posedge mclk_i) #1 reg_reset_i = 1'b1;
		@(posedge mclk_i) #1 reg_reset_i = 1'b0;
		evt(9'h004, 1'b1);
		rchk(mask_low_addr, 8'h00);
		rchk(mask_high_addr, 8'h00);
		$display("charger events done");
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk_i) #1 fault_levels_i = 8'h01 << i;
			repeat (8) @(posedge mclk_i);
			rchk(fault_flags_addr, i < 3 ? 8'h01 : 8'h01 << i);
			@(posedge mclk_i) #1 fault_levels_i = '0;
			repeat (8) @(posedge mclk_i);
			rchk(fault_flags_addr, i < 3 ? 8'h01 : 8'h00);
		end
		$display("faults done");
		final_report;
	end
	initial begin
		#50000;
		miscompares++;
		final_report;
	end
endmodule // charger_event_irq_tb
bind charger_event_irq event_irq_properties event_irq_properties_inst (.*);
